// ---- logic/radio_cfg_pkg.sv ----
// Purpose: Shared constants and types for the radio state control config.
// Assumes: Byte-wide register port, registers at fixed offsets.
// Notes:   Reserved fields hold fixed values and ignore writes.
`default_nettype none
package radio_cfg_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [5:0] POST_TX_STATE_CONFIG_ADDR       = 6'h17;
  localparam logic [5:0] CALIBRATION_TIMEOUT_CONFIG_ADDR = 6'h18;

  // ==========================================================
  // Field positions
  localparam int NEXT_STATE_LSB = 0;
  localparam int RSV_TX_LSB     = 2;
  localparam int PO_SELECT_LSB  = 2;
  localparam int AUTOCAL_LSB    = 4;

  // ==========================================================
  // Reset and fixed values
  localparam logic [1:0] NEXT_STATE_RESET = 2'h0;
  localparam logic [3:0] RSV_TX_VALUE     = 4'hC;
  localparam logic [1:0] AUTOCAL_RESET    = 2'h0;
  localparam logic [1:0] PO_SELECT_RESET  = 2'h1;
  localparam logic [1:0] RSV_CAL_VALUE    = 2'h0;

  // ==========================================================
  // Timing counts
  localparam int         RIPPLE_WIDTH = 6;
  localparam int         EXPIRE_WIDTH = 9;
  localparam logic [8:0] EXPIRE_SEL0  = 9'h001;
  localparam logic [8:0] EXPIRE_SEL1  = 9'h010;
  localparam logic [8:0] EXPIRE_SEL2  = 9'h040;
  localparam logic [8:0] EXPIRE_SEL3  = 9'h100;
  localparam logic [1:0] CAL_EVERY_NTH_LAST = 2'h3;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    POST_TX_IDLE  = 2'b00,
    POST_TX_FSTX  = 2'b01,
    POST_TX_STAY  = 2'b10,
    POST_TX_UNDEF = 2'b11
  } post_tx_e;

  typedef enum logic [1:0] {
    AUTOCAL_NEVER      = 2'b00,
    AUTOCAL_ENTER_TX   = 2'b01,
    AUTOCAL_LEAVE_TX   = 2'b10,
    AUTOCAL_LEAVE_4TH  = 2'b11
  } autocal_e;

  typedef enum logic [1:0] {
    GO_IDLE        = 2'b00,
    GO_SYNTH_ON_TX = 2'b01,
    GO_STAY_TX     = 2'b10
  } tx_end_target_e;

  typedef struct packed {
    post_tx_e   post_transmit_next_state;
    autocal_e   synth_auto_calibration_select;
    logic [1:0] power_on_expire_select;
  } radio_cfg_s;

  typedef struct packed {
    logic manual_calibrate_strobe;
    logic idle_to_tx;
    logic tx_to_idle;
    logic packet_done;
  } radio_event_s;

  function automatic logic [8:0] expire_count(input logic [1:0] sel);
    logic [8:0] r;
    r = EXPIRE_SEL0;
    unique case (sel)
      2'h0: r = EXPIRE_SEL0;
      2'h1: r = EXPIRE_SEL1;
      2'h2: r = EXPIRE_SEL2;
      2'h3: r = EXPIRE_SEL3;
    endcase
    return r;
  endfunction : expire_count

endpackage : radio_cfg_pkg
`default_nettype wire

// ---- logic/power_on_timer.sv ----
// Purpose: Holds charge pump ready off until the ripple counter has expired expire_target times.
// Assumes: Oscillator stable level already synchronised to clk.
// Notes:   Losing oscillator stability restarts the whole wait.
`timescale 1ns/1ps
`default_nettype none
module power_on_timer
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       osc_stable,
  input  wire logic [8:0] expire_target,
  output logic            charge_pump_ready_low
);

  logic [radio_cfg_pkg::RIPPLE_WIDTH-1:0] ripple;
  logic [radio_cfg_pkg::RIPPLE_WIDTH-1:0] next_ripple;
  logic [radio_cfg_pkg::EXPIRE_WIDTH-1:0] expires;
  logic [radio_cfg_pkg::EXPIRE_WIDTH-1:0] next_expires;
  logic                                   next_ready_low;
  logic                                   done;

  // ==========================================================
  // Ripple counting
  // Compared live so a late field change still ends the wait sanely
  assign done = (expires >= expire_target);

  always_comb
  begin
    next_ripple    = ripple;
    next_expires   = expires;
    next_ready_low = 1'b1;
    if (!osc_stable)
    begin
      next_ripple  = '0;
      next_expires = '0;
    end
    else if (!done)
    begin
      next_ripple = ripple + 1'b1;
      if (&ripple)
        next_expires = expires + 1'b1;
    end
    else
      next_ready_low = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ripple                <= '0;
      expires               <= '0;
      charge_pump_ready_low <= 1'b1;
    end
    else
    begin
      ripple                <= next_ripple;
      expires               <= next_expires;
      charge_pump_ready_low <= next_ready_low;
    end
  end

endmodule : power_on_timer
`default_nettype wire

// ---- logic/radio_state_control_config.sv ----
// Purpose: Post-transmit state, auto calibration and power-on wait config.
// Assumes: Register port driven by the serial interface front end on clk.
// Notes:   Reserved register bits are constants and ignore writes.
// Notes on behaviour
// - Post-transmit code 0 returns to idle, 1 to synth-on ready; reset 0.
// - Post-transmit code 2 stays in transmit and restarts preamble.
// - Auto-calibration code 0 calibrates only on the manual strobe.
// - Code 1 calibrates on each move from idle into transmit or ready.
// - Code 2 calibrates on each transmit-to-idle, code 3 on every fourth.
// - After the oscillator is stable the ripple counter expires N times.
// - Power-on select 0,1,2,3 gives 1,16,64,256 expiries; reset 1.
`timescale 1ns/1ps
`default_nettype none
module radio_state_control_config
(
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic [5:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic      [7:0]                 reg_rdata,
  input  wire radio_cfg_pkg::radio_event_s events,
  input  wire logic                       osc_stable_pin,
  output var radio_cfg_pkg::tx_end_target_e tx_end_target,
  output logic                            tx_end_valid,
  output logic                            calibrate_start,
  output logic                            charge_pump_ready_low
);

  radio_cfg_pkg::radio_cfg_s     cfg;
  radio_cfg_pkg::radio_cfg_s     next_cfg;
  logic [7:0]                    next_rdata;
  radio_cfg_pkg::tx_end_target_e next_tx_end_target;
  logic                          next_tx_end_valid;
  logic                          next_calibrate_start;
  logic [1:0]                    leave_count;
  logic [1:0]                    next_leave_count;
  logic                          stable_meta;
  logic                          stable_sync;
  logic [8:0]                    expire_target;

  // ==========================================================
  // Register writes
  always_comb
  begin
    next_cfg = cfg;
    if (reg_write)
    begin
      if (reg_addr == radio_cfg_pkg::POST_TX_STATE_CONFIG_ADDR)
        next_cfg.post_transmit_next_state = radio_cfg_pkg::post_tx_e'(
          reg_wdata[radio_cfg_pkg::NEXT_STATE_LSB +: 2]);
      else if (reg_addr == radio_cfg_pkg::CALIBRATION_TIMEOUT_CONFIG_ADDR)
      begin
        next_cfg.synth_auto_calibration_select = radio_cfg_pkg::autocal_e'(
          reg_wdata[radio_cfg_pkg::AUTOCAL_LSB +: 2]);
        next_cfg.power_on_expire_select =
          reg_wdata[radio_cfg_pkg::PO_SELECT_LSB +: 2];
      end
    end
  end

  // ==========================================================
  // Register reads
  // Read beside a write in one cycle returns the old value
  always_comb
  begin
    next_rdata = reg_rdata;
    if (reg_read)
    begin
      next_rdata = 8'h00;
      if (reg_addr == radio_cfg_pkg::POST_TX_STATE_CONFIG_ADDR)
      begin
        next_rdata[radio_cfg_pkg::RSV_TX_LSB +: 4] =
          radio_cfg_pkg::RSV_TX_VALUE;
        next_rdata[radio_cfg_pkg::NEXT_STATE_LSB +: 2] =
          cfg.post_transmit_next_state;
      end
      else if (reg_addr == radio_cfg_pkg::CALIBRATION_TIMEOUT_CONFIG_ADDR)
      begin
        next_rdata[radio_cfg_pkg::AUTOCAL_LSB +: 2] =
          cfg.synth_auto_calibration_select;
        next_rdata[radio_cfg_pkg::PO_SELECT_LSB +: 2] =
          cfg.power_on_expire_select;
        next_rdata[1:0] = radio_cfg_pkg::RSV_CAL_VALUE;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg.post_transmit_next_state <= radio_cfg_pkg::post_tx_e'(
        radio_cfg_pkg::NEXT_STATE_RESET);
      cfg.synth_auto_calibration_select <= radio_cfg_pkg::autocal_e'(
        radio_cfg_pkg::AUTOCAL_RESET);
      cfg.power_on_expire_select <= radio_cfg_pkg::PO_SELECT_RESET;
      reg_rdata <= 8'h00;
    end
    else
    begin
      cfg       <= next_cfg;
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // End of packet target
  // Undefined code 3 falls back to idle rather than locking up
  // Target holds between packets, valid marks a fresh one
  always_comb
  begin
    next_tx_end_valid  = events.packet_done;
    next_tx_end_target = tx_end_target;
    if (events.packet_done)
    begin
      unique case (cfg.post_transmit_next_state)
        radio_cfg_pkg::POST_TX_IDLE:
          next_tx_end_target = radio_cfg_pkg::GO_IDLE;
        radio_cfg_pkg::POST_TX_FSTX:
          next_tx_end_target = radio_cfg_pkg::GO_SYNTH_ON_TX;
        radio_cfg_pkg::POST_TX_STAY:
          next_tx_end_target = radio_cfg_pkg::GO_STAY_TX;
        radio_cfg_pkg::POST_TX_UNDEF:
          next_tx_end_target = radio_cfg_pkg::GO_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_end_target <= radio_cfg_pkg::GO_IDLE;
      tx_end_valid  <= 1'b0;
    end
    else
    begin
      tx_end_target <= next_tx_end_target;
      tx_end_valid  <= next_tx_end_valid;
    end
  end

  // ==========================================================
  // Calibration triggers
  // Coincident causes merge into one pulse
  // Counter kept across mode changes, so a switch back resumes
  always_comb
  begin
    next_leave_count     = leave_count;
    next_calibrate_start = events.manual_calibrate_strobe;
    unique case (cfg.synth_auto_calibration_select)
      radio_cfg_pkg::AUTOCAL_NEVER:
        next_leave_count = leave_count;
      radio_cfg_pkg::AUTOCAL_ENTER_TX:
        if (events.idle_to_tx)
          next_calibrate_start = 1'b1;
      radio_cfg_pkg::AUTOCAL_LEAVE_TX:
        if (events.tx_to_idle)
          next_calibrate_start = 1'b1;
      radio_cfg_pkg::AUTOCAL_LEAVE_4TH:
        if (events.tx_to_idle)
        begin
          next_leave_count = leave_count + 1'b1;
          if (leave_count == radio_cfg_pkg::CAL_EVERY_NTH_LAST)
            next_calibrate_start = 1'b1;
        end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      leave_count     <= 2'h0;
      calibrate_start <= 1'b0;
    end
    else
    begin
      leave_count     <= next_leave_count;
      calibrate_start <= next_calibrate_start;
    end
  end

  // ==========================================================
  // Oscillator stable synchroniser
  // Pin is asynchronous to clk, so two stages before any use
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stable_meta <= 1'b0;
      stable_sync <= 1'b0;
    end
    else
    begin
      stable_meta <= osc_stable_pin;
      stable_sync <= stable_meta;
    end
  end

  // ==========================================================
  // Power-on wait
  // Decoded here so the timer stays a plain counter
  assign expire_target =
    radio_cfg_pkg::expire_count(cfg.power_on_expire_select);

  power_on_timer u_power_on_timer
  (
    .clk                   (clk),
    .arst_n                (arst_n),
    .osc_stable            (stable_sync),
    .expire_target         (expire_target),
    .charge_pump_ready_low (charge_pump_ready_low)
  );

endmodule : radio_state_control_config
`default_nettype wire

// ---- verif/radio_state_control_config_sva.sv ----
// Purpose: Port-level checks for the radio state control config.
// Assumes: Shadow copies of the fields follow accepted writes.
// Notes:   Power-on checks assume select is not changed while stable.
`timescale 1ns/1ps
`default_nettype none
module radio_state_control_config_sva
(
  input wire logic                          clk,
  input wire logic                          arst_n,
  input wire logic [5:0]                    reg_addr,
  input wire logic [7:0]                    reg_wdata,
  input wire logic                          reg_write,
  input wire logic                          reg_read,
  input wire logic [7:0]                    reg_rdata,
  input wire radio_cfg_pkg::radio_event_s   events,
  input wire logic                          osc_stable_pin,
  input wire radio_cfg_pkg::tx_end_target_e tx_end_target,
  input wire logic                          tx_end_valid,
  input wire logic                          calibrate_start,
  input wire logic                          charge_pump_ready_low
);
  logic [1:0]  nx, ac, sel, cnt, tgt;
  logic [16:0] st, lim;
  logic        cause;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Shadow state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nx <= 2'h0;
      ac <= 2'h0;
      sel <= 2'h1;
      cnt <= 2'h0;
      st <= 17'h0;
    end
    else
    begin
      if (reg_write && reg_addr == 6'h17)
        nx <= reg_wdata[1:0];
      if (reg_write && reg_addr == 6'h18)
      begin
        ac <= reg_wdata[5:4];
        sel <= reg_wdata[3:2];
      end
      if (events.tx_to_idle && ac == 2'h3)
        cnt <= cnt + 2'h1;
      st <= osc_stable_pin ? st + 17'h1 : 17'h0;
    end
  end
  assign tgt = (nx == 2'h3) ? 2'h0 : nx;
  assign lim = (sel == 2'h0) ? 17'h00040 : (sel == 2'h1) ? 17'h00400 :
               (sel == 2'h2) ? 17'h01000 : 17'h04000;
  assign cause = events.manual_calibrate_strobe |
                 (ac == 2'h1 & events.idle_to_tx) |
                 (ac == 2'h2 & events.tx_to_idle) |
                 (ac == 2'h3 & events.tx_to_idle & cnt == 2'h3);
  // ==========================================================
  // Assertions
  a_cal_cause: assert property (cause |=> calibrate_start)
    else $error("calibration pulse missing");
  a_cal_only: assert property (calibrate_start |-> $past(cause))
    else $error("calibration pulse without cause");
  a_done_valid: assert property (events.packet_done |=> tx_end_valid)
    else $error("tx end not flagged");
  a_target_map: assert property (tx_end_valid |->
    tx_end_target == $past(tgt)) else $error("wrong tx end target");
  a_read_post: assert property (reg_read && reg_addr == 6'h17 |=>
    reg_rdata == {2'h0, 4'hC, $past(nx)}) else $error("post tx readback");
  a_read_cal: assert property (reg_read && reg_addr == 6'h18 |=>
    reg_rdata == {2'h0, $past(ac), $past(sel), 2'h0})
    else $error("calibration config readback");
  a_ready_early: assert property (!charge_pump_ready_low &&
    osc_stable_pin |-> st >= lim) else $error("ready too early");
  a_ready_late: assert property (st >= lim + 17'h8 |->
    !charge_pump_ready_low) else $error("ready too late");
  a_ready_drop: assert property (!osc_stable_pin [*4] |=>
    charge_pump_ready_low) else $error("ready held without oscillator");
endmodule : radio_state_control_config_sva
bind radio_state_control_config radio_state_control_config_sva u_sva
(
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .events(events), .osc_stable_pin(osc_stable_pin),
  .tx_end_target(tx_end_target), .tx_end_valid(tx_end_valid),
  .calibrate_start(calibrate_start),
  .charge_pump_ready_low(charge_pump_ready_low)
);
`default_nettype wire

// ---- verif/test_radio_state_control_config.sv ----
// Purpose: Self-checking bench for the radio state control config.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes:   Runs all four power-on selects, about 22000 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_radio_state_control_config;
  typedef struct packed
  {
    logic [7:0] wd;
    logic [7:0] rd;
    logic [7:0] tg;
  } row_s;
  logic                          clk = 1'b0;
  logic                          arst_n = 1'b0;
  logic [5:0]                    reg_addr = 6'h00;
  logic [7:0]                    reg_wdata = 8'h00;
  logic                          reg_write = 1'b0;
  logic                          reg_read = 1'b0;
  logic [7:0]                    reg_rdata, got;
  radio_cfg_pkg::radio_event_s   events = '0;
  logic                          osc_stable_pin = 1'b0;
  radio_cfg_pkg::tx_end_target_e tx_end_target;
  logic                          tx_end_valid, calibrate_start;
  logic                          charge_pump_ready_low;
  int                            error_cnt = 0, n_compared = 0, n;
  int                            lim[4] = '{64, 1024, 4096, 16384};
  row_s rows[3] = '{'{8'h00, 8'h30, 8'h04}, '{8'h01, 8'h31, 8'h05},
                    '{8'hFE, 8'h32, 8'h06}}; // code 3 never written
  always #5 clk = ~clk;
  radio_state_control_config u_dut
  (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .events(events),
    .osc_stable_pin(osc_stable_pin), .tx_end_target(tx_end_target),
    .tx_end_valid(tx_end_valid), .calibrate_start(calibrate_start),
    .charge_pump_ready_low(charge_pump_ready_low)
  );
  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    got = reg_rdata;
  endtask : rd
  task automatic ev(input logic [3:0] e, input logic cal);
    @(posedge clk);
    events <= radio_cfg_pkg::radio_event_s'(e);
    @(posedge clk);
    events <= '0;
    @(negedge clk);
    chk({7'h0, calibrate_start}, {7'h0, cal});
  endtask : ev
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // ==========================================================
  // Watchdog
  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  // ==========================================================
  // Tests
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i])
    begin
      wr(6'h17, rows[i].wd);
      rd(6'h17);
      chk(got, rows[i].rd);
      ev(4'h1, 1'b0);
      chk({5'h0, tx_end_valid, tx_end_target}, rows[i].tg);
    end
    $display("test table done");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(6'h17);
    chk(got, 8'h30);
    rd(6'h18);
    chk(got, 8'h04);
    rd(6'h19);
    chk(got, 8'h00);
    $display("test reset done");
    ev(4'h4, 1'b0);
    ev(4'h2, 1'b0);
    ev(4'h8, 1'b1);
    wr(6'h18, 8'h10);
    ev(4'h4, 1'b1);
    ev(4'h2, 1'b0);
    wr(6'h18, 8'h20);
    ev(4'h2, 1'b1);
    ev(4'h4, 1'b0);
    wr(6'h18, 8'hF3);
    rd(6'h18);
    chk(got, 8'h30);
    repeat (3) ev(4'h2, 1'b0);
    ev(4'h2, 1'b1);
    $display("test calibration done");
    for (int s = 0; s < 4; s++)
    begin
      wr(6'h18, 8'(s << 2));
      osc_stable_pin <= 1'b1;
      n = 0;
      // Look between edges so the new ready value has settled
      while (charge_pump_ready_low !== 1'b0 && n < 20000)
      begin
        @(negedge clk);
        n++;
      end
      chk({7'h0, n >= lim[s] && n <= lim[s] + 8}, 8'h01);
      @(posedge clk);
      osc_stable_pin <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({7'h0, charge_pump_ready_low}, 8'h01);
    end
    $display("test power on done");
    summarize();
  end
endmodule : test_radio_state_control_config
`default_nettype wire
